/* design/abs_pkg.sv */
// Package: register map, opcode patterns, status layout and state types for the ALU/branch slice
package abs_pkg;

  // APB register byte offsets
  localparam logic [7:0] ABS_OFF_CTRL = 8'h00;
  localparam logic [7:0] ABS_OFF_INSTR = 8'h04;
  localparam logic [7:0] ABS_OFF_WREG = 8'h08;
  localparam logic [7:0] ABS_OFF_STATUS = 8'h0C;
  localparam logic [7:0] ABS_OFF_BANK = 8'h10;
  localparam logic [7:0] ABS_OFF_PC = 8'h14;
  localparam logic [7:0] ABS_OFF_INDEX = 8'h18;
  localparam logic [7:0] ABS_OFF_CORE = 8'h1C;

  // Status flag bit positions
  localparam int ABS_ST_C = 0;
  localparam int ABS_ST_DC = 1;
  localparam int ABS_ST_Z = 2;
  localparam int ABS_ST_OV = 3;
  localparam int ABS_ST_N = 4;

  // Core state bit positions in the CORE register
  localparam int ABS_CORE_BUSY = 0;
  localparam int ABS_CORE_ILLEGAL = 1;
  localparam int ABS_CORE_TAKEN = 2;

  // Reset values
  localparam logic [7:0] ABS_RST_WREG = 8'h00;
  localparam logic [4:0] ABS_RST_STATUS = 5'h00;
  localparam logic [3:0] ABS_RST_BANK = 4'h0;
  localparam logic [20:0] ABS_RST_PC = 21'h000000;
  localparam logic [11:0] ABS_RST_INDEX = 12'h000;
  localparam logic [15:0] ABS_RST_INSTR = 16'h0000;

  // Opcode patterns
  localparam logic [5:0] ABS_OPC_ADC = 6'h08;
  localparam logic [7:0] ABS_OPC_ANDL = 8'h0B;
  localparam logic [5:0] ABS_OPC_ANDF = 6'h05;
  localparam logic [3:0] ABS_OPC_BCLR = 4'h9;
  localparam logic [7:0] ABS_OPC_BC = 8'hE2;
  localparam logic [7:0] ABS_OPC_BNC = 8'hE3;
  localparam logic [7:0] ABS_OPC_BN = 8'hE6;
  localparam logic [7:0] ABS_OPC_BNN = 8'hE7;
  localparam logic [7:0] ABS_OPC_BRANCH_ON_OVERFLOW_CLEAR = 8'hE5;
  localparam logic [7:0] ABS_OPC_BNZ = 8'hE1;

  // Addressing
  localparam logic [7:0] ABS_ACC_SPLIT = 8'h60;
  localparam logic [7:0] ABS_IDX_MAX = 8'h5F;
  localparam logic [3:0] ABS_BANK_LOW = 4'h0;
  localparam logic [3:0] ABS_BANK_SFR = 4'hF;
  localparam logic [20:0] ABS_PC_STEP = 21'h000002;

  typedef enum logic [2:0] {
    ABS_PH_IDLE, ABS_PH_Q1, ABS_PH_Q2, ABS_PH_Q3, ABS_PH_Q4
  } abs_phase_t;

  typedef enum logic [2:0] {
    ABS_OP_NONE, ABS_OP_ADC, ABS_OP_ANDL, ABS_OP_ANDF, ABS_OP_BCLR, ABS_OP_BR
  } abs_op_t;

  typedef struct packed {
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } abs_mem_req_t;

  typedef struct packed {
    abs_phase_t phase;
    logic nop;
    abs_op_t op;
    logic [15:0] instr;
    logic [7:0] wreg;
    logic [4:0] status;
    logic [3:0] bank;
    logic [20:0] pc;
    logic [11:0] index;
    logic ext_en;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [4:0] flg;
    logic taken;
    logic illegal;
    logic last_taken;
    abs_mem_req_t mem;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } abs_state_t;

endpackage

/* design/abs_core.sv */
// ALU and conditional branch execute slice with APB register access
`timescale 1ns/100ps

// Functional notes
// [RULE_01] Add-with-carry sums W, byte, carry; sets five flags
// [RULE_02] Destination bit zero to W, one to file
// [RULE_03] Access bit zero quick bank, one bank pointer
// [RULE_04] Extended mode, access zero, f<=95: indexed offset
// [RULE_05] Immediate AND into W, only sign and zero
// [RULE_06] Register AND to destination, only sign and zero
// [RULE_07] Bit clear one bit, flags untouched
// [RULE_08] Carry branches test carry, flags untouched
// [RULE_09] Sign branches test negative, flags untouched
// [RULE_10] Overflow-clear branch taken when overflow zero
// [RULE_11] Nonzero branch taken when zero flag clear
// [RULE_12] Target is incremented PC plus twice offset
// [RULE_13] Branch one cycle, two when taken
// [RULE_14] Add, AND, bit clear: one word, one cycle
module abs_core
  import abs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] mem_rdata,
  output abs_mem_req_t mem_req
);

  abs_state_t st;
  abs_state_t next_st;

  function automatic abs_op_t abs_decode(input logic [15:0] iw);
    abs_op_t op;
    op = ABS_OP_NONE;
    if (iw[15:10] == ABS_OPC_ADC) begin
      op = ABS_OP_ADC;
    end else if (iw[15:8] == ABS_OPC_ANDL) begin
      op = ABS_OP_ANDL;
    end else if (iw[15:10] == ABS_OPC_ANDF) begin
      op = ABS_OP_ANDF;
    end else if (iw[15:12] == ABS_OPC_BCLR) begin
      op = ABS_OP_BCLR;
    end else if (iw[15:8] == ABS_OPC_BC || iw[15:8] == ABS_OPC_BNC ||
                 iw[15:8] == ABS_OPC_BN || iw[15:8] == ABS_OPC_BNN ||
                 iw[15:8] == ABS_OPC_BRANCH_ON_OVERFLOW_CLEAR || iw[15:8] == ABS_OPC_BNZ) begin
      op = ABS_OP_BR;
    end
    return op;
  endfunction

  // Branch condition from the opcode byte and the current flags
  function automatic logic abs_cond(input logic [7:0] opc, input logic [4:0] s);
    logic c;
    c = 1'b0;
    case (opc)
      ABS_OPC_BC: c = s[ABS_ST_C]; // see [RULE_08]
      ABS_OPC_BNC: c = !s[ABS_ST_C]; // see [RULE_08]
      ABS_OPC_BN: c = s[ABS_ST_N]; // see [RULE_09]
      ABS_OPC_BNN: c = !s[ABS_ST_N]; // see [RULE_09]
      ABS_OPC_BRANCH_ON_OVERFLOW_CLEAR: c = !s[ABS_ST_OV]; // see [RULE_10]
      ABS_OPC_BNZ: c = !s[ABS_ST_Z]; // see [RULE_11]
      default: c = 1'b0;
    endcase
    return c;
  endfunction

  // Data memory address for the file operand of a register opcode
  function automatic logic [11:0] abs_faddr(input logic [15:0] iw, input logic [3:0] bank,
                                            input logic ext, input logic [11:0] idx);
    logic [11:0] a;
    a = {bank, iw[7:0]};
    if (!iw[8]) begin
      if (ext && iw[7:0] <= ABS_IDX_MAX) begin
        a = 12'(idx + {4'h0, iw[7:0]}); // see [RULE_04]
      end else if (iw[7:0] < ABS_ACC_SPLIT) begin
        a = {ABS_BANK_LOW, iw[7:0]}; // see [RULE_03]
      end else begin
        a = {ABS_BANK_SFR, iw[7:0]}; // see [RULE_03]
      end
    end
    return a;
  endfunction

  logic [8:0] adc_sum;
  logic [4:0] adc_low;
  logic [7:0] and_src;
  logic [7:0] and_res;
  logic [7:0] clr_res;
  logic [20:0] br_off;
  logic idle;

  assign idle = (st.phase == ABS_PH_IDLE);
  assign adc_sum = {1'b0, st.wreg} + {1'b0, mem_rdata} + {8'h00, st.status[ABS_ST_C]};
  assign adc_low = {1'b0, st.wreg[3:0]} + {1'b0, mem_rdata[3:0]} +
                   {4'h0, st.status[ABS_ST_C]};
  assign and_src = (st.op == ABS_OP_ANDL) ? st.instr[7:0] : mem_rdata;
  assign and_res = st.wreg & and_src;
  assign clr_res = mem_rdata & ~(8'h01 << st.instr[11:9]);
  assign br_off = {{12{st.instr[7]}}, st.instr[7:0], 1'b0};

  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.mem.rd = 1'b0;
    next_st.mem.wr = 1'b0;

    // Two-cycle access phase so every answer comes from a flop
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h00000000;
      case (paddr)
        ABS_OFF_CTRL: begin
          next_st.prdata = {31'h00000000, st.ext_en};
          if (pwrite) begin
            next_st.ext_en = pwdata[0];
          end
        end
        ABS_OFF_INSTR: begin
          next_st.prdata = {16'h0000, st.instr};
          // A new instruction is refused while one is executing
          if (pwrite && idle) begin
            next_st.instr = pwdata[15:0];
            next_st.phase = ABS_PH_Q1;
            next_st.nop = 1'b0;
          end
        end
        ABS_OFF_WREG: begin
          next_st.prdata = {24'h000000, st.wreg};
          if (pwrite && idle) begin
            next_st.wreg = pwdata[7:0];
          end
        end
        ABS_OFF_STATUS: begin
          next_st.prdata = {27'h0000000, st.status};
          if (pwrite && idle) begin
            next_st.status = pwdata[4:0];
          end
        end
        ABS_OFF_BANK: begin
          next_st.prdata = {28'h0000000, st.bank};
          if (pwrite && idle) begin
            next_st.bank = pwdata[3:0];
          end
        end
        ABS_OFF_PC: begin
          next_st.prdata = {11'h000, st.pc};
          if (pwrite && idle) begin
            next_st.pc = {pwdata[20:1], 1'b0};
          end
        end
        ABS_OFF_INDEX: begin
          next_st.prdata = {20'h00000, st.index};
          if (pwrite && idle) begin
            next_st.index = pwdata[11:0];
          end
        end
        ABS_OFF_CORE: begin
          next_st.prdata = {29'h00000000, st.last_taken, st.illegal, !idle};
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end

    case (st.phase)
      ABS_PH_IDLE: begin
        next_st.nop = 1'b0;
      end
      ABS_PH_Q1: begin
        next_st.phase = ABS_PH_Q2;
        if (!st.nop) begin
          next_st.op = abs_decode(st.instr);
          next_st.illegal = (abs_decode(st.instr) == ABS_OP_NONE);
          next_st.pc = 21'(st.pc + ABS_PC_STEP);
          next_st.mem.addr = abs_faddr(st.instr, st.bank, st.ext_en, st.index);
          // Read strobe lands in Q2; the byte is back in Q3
          next_st.mem.rd = (abs_decode(st.instr) == ABS_OP_ADC) ||
                           (abs_decode(st.instr) == ABS_OP_ANDF) ||
                           (abs_decode(st.instr) == ABS_OP_BCLR);
        end
      end
      ABS_PH_Q2: begin
        next_st.phase = ABS_PH_Q3;
      end
      ABS_PH_Q3: begin
        next_st.phase = ABS_PH_Q4;
        if (!st.nop) begin
          next_st.opnd = and_src;
          next_st.flg = st.status;
          next_st.taken = 1'b0;
          case (st.op)
            ABS_OP_ADC: begin
              next_st.res = adc_sum[7:0]; // see [RULE_01]
              next_st.flg[ABS_ST_C] = adc_sum[8];
              next_st.flg[ABS_ST_DC] = adc_low[4];
              next_st.flg[ABS_ST_Z] = (adc_sum[7:0] == 8'h00);
              next_st.flg[ABS_ST_N] = adc_sum[7];
              next_st.flg[ABS_ST_OV] = (st.wreg[7] == mem_rdata[7]) &&
                                       (adc_sum[7] != st.wreg[7]);
            end
            ABS_OP_ANDL, ABS_OP_ANDF: begin
              next_st.res = and_res; // see [RULE_05] [RULE_06]
              next_st.flg[ABS_ST_Z] = (and_res == 8'h00);
              next_st.flg[ABS_ST_N] = and_res[7];
            end
            ABS_OP_BCLR: begin
              next_st.res = clr_res; // see [RULE_07]
            end
            ABS_OP_BR: begin
              next_st.taken = abs_cond(st.instr[15:8], st.status);
            end
            default: begin
              next_st.res = st.res;
            end
          endcase
          // File write strobe stands through Q4
          next_st.mem.wdata = (st.op == ABS_OP_BCLR) ? clr_res :
                              (st.op == ABS_OP_ADC) ? adc_sum[7:0] : and_res;
          next_st.mem.wr = (st.op == ABS_OP_BCLR) ||
                           ((st.op == ABS_OP_ADC || st.op == ABS_OP_ANDF) &&
                            st.instr[9]); // see [RULE_02]
        end
      end
      ABS_PH_Q4: begin
        next_st.phase = ABS_PH_IDLE; // see [RULE_14]
        if (!st.nop) begin
          next_st.last_taken = st.taken;
          case (st.op)
            ABS_OP_ADC, ABS_OP_ANDF: begin
              if (!st.instr[9]) begin
                next_st.wreg = st.res; // see [RULE_02]
              end
              next_st.status = st.flg;
            end
            ABS_OP_ANDL: begin
              next_st.wreg = st.res;
              next_st.status = st.flg;
            end
            ABS_OP_BR: begin
              if (st.taken) begin
                next_st.pc = 21'(st.pc + br_off); // see [RULE_12]
                next_st.phase = ABS_PH_Q1; // see [RULE_13]
                next_st.nop = 1'b1;
              end
            end
            default: begin
              next_st.status = st.status;
            end
          endcase
        end
      end
      default: begin
        next_st.phase = ABS_PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.phase <= ABS_PH_IDLE;
      st.op <= ABS_OP_NONE;
      st.instr <= ABS_RST_INSTR;
      st.wreg <= ABS_RST_WREG;
      st.status <= ABS_RST_STATUS;
      st.bank <= ABS_RST_BANK;
      st.pc <= ABS_RST_PC;
      st.index <= ABS_RST_INDEX;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign mem_req = st.mem;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic q1_go;
  assign q1_go = (st.phase == ABS_PH_Q1) && !st.nop;

  sequence s_body;
    st.phase == ABS_PH_Q1 ##1 st.phase == ABS_PH_Q2 ##1
    st.phase == ABS_PH_Q3 ##1 st.phase == ABS_PH_Q4;
  endsequence

  sequence s_nop_cycle;
    (st.phase == ABS_PH_Q1 && st.nop) ##1 st.phase == ABS_PH_Q2 ##1
    st.phase == ABS_PH_Q3 ##1 st.phase == ABS_PH_Q4;
  endsequence

  property p_adc_sum;
    (st.phase == ABS_PH_Q3 && !st.nop && st.op == ABS_OP_ADC) |=>
      st.res == 8'($past(st.wreg) + $past(mem_rdata) + {7'h00, $past(st.status[ABS_ST_C])});
  endproperty
  a_adc_sum: assert property (p_adc_sum) else $error("add with carry result wrong"); // see [RULE_01]

  property p_dest_w;
    (st.phase == ABS_PH_Q4 && !st.nop && !st.instr[9] &&
     (st.op == ABS_OP_ADC || st.op == ABS_OP_ANDF)) |-> !st.mem.wr ##1 st.wreg == $past(st.res);
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("result not routed to W"); // see [RULE_02]

  property p_dest_f;
    (st.phase == ABS_PH_Q4 && !st.nop && st.instr[9] &&
     (st.op == ABS_OP_ADC || st.op == ABS_OP_ANDF)) |->
      st.mem.wr && st.mem.wdata == st.res ##1 $stable(st.wreg);
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("result not written to file"); // see [RULE_02]

  property p_bank_sel;
    (st.phase == ABS_PH_Q2 && st.mem.rd && st.instr[8]) |->
      st.mem.addr == {st.bank, st.instr[7:0]};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank pointer not used"); // see [RULE_03]

  property p_indexed;
    (st.phase == ABS_PH_Q2 && st.mem.rd && !st.instr[8] && st.ext_en &&
     st.instr[7:0] <= ABS_IDX_MAX) |-> st.mem.addr == 12'(st.index + {4'h0, st.instr[7:0]});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed offset address wrong"); // see [RULE_04]

  property p_and_flags;
    (st.phase == ABS_PH_Q4 && !st.nop && (st.op == ABS_OP_ANDL || st.op == ABS_OP_ANDF)) |=>
      st.status[ABS_ST_C] == $past(st.status[ABS_ST_C]) &&
      st.status[ABS_ST_OV] == $past(st.status[ABS_ST_OV]) &&
      st.status[ABS_ST_Z] == ($past(st.res) == 8'h00);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("AND changed wrong flags"); // see [RULE_05] [RULE_06]

  property p_bclr;
    (q1_go && abs_decode(st.instr) == ABS_OP_BCLR) |->
      ##3 (st.mem.wdata[st.instr[11:9]] == 1'b0 && $stable(st.status)) ##1 $stable(st.status);
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear wrong"); // see [RULE_07]

  property p_br_flags;
    (q1_go && abs_decode(st.instr) == ABS_OP_BR) |-> ##1 $stable(st.status) [*4];
  endproperty
  a_br_flags: assert property (p_br_flags) else $error("branch changed flags"); // see [RULE_08] [RULE_09]

  property p_br_taken;
    (q1_go && abs_decode(st.instr) == ABS_OP_BR && abs_cond(st.instr[15:8], st.status)) |->
      s_body ##1 s_nop_cycle ##1 st.phase == ABS_PH_IDLE;
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("taken branch not two cycles"); // see [RULE_13]

  property p_br_target;
    (st.phase == ABS_PH_Q4 && !st.nop && st.op == ABS_OP_BR && st.taken) |=>
      st.pc == 21'($past(st.pc) + {{12{$past(st.instr[7])}}, $past(st.instr[7:0]), 1'b0});
  endproperty
  a_br_target: assert property (p_br_target) else $error("branch target wrong"); // see [RULE_12]

  property p_one_cycle;
    (q1_go && !(abs_decode(st.instr) == ABS_OP_BR && abs_cond(st.instr[15:8], st.status))) |->
      s_body ##1 st.phase == ABS_PH_IDLE;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("single cycle op overran"); // see [RULE_14] [RULE_13]

endmodule

/* tb/abs_mem_model.sv */
// Data memory model that answers the core's byte read and write requests
`timescale 1ns/100ps
module abs_mem_model
  import abs_pkg::*;
(
  input wire logic sys_clk,
  input wire abs_mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:4095];

  initial begin
    mem_rdata = 8'hA5;
    foreach (mem[i]) begin
      mem[i] = 8'h00;
    end
  end

  // Read byte is valid only in the cycle after the strobe; otherwise the bus flips every
  // cycle so a core that samples late cannot pick up a stale match by luck
  always @(posedge sys_clk) begin
    if (mem_req.rd === 1'b1) begin
      mem_rdata <= mem[mem_req.addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_req.wr === 1'b1) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end
endmodule

/* tb/test_alu_branch_instruction_slice.sv */
// Self-checking testbench for the ALU and branch execute slice
`timescale 1ns/100ps
module test_alu_branch_instruction_slice;
  import abs_pkg::*;

  logic sys_clk;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] mem_rdata;
  abs_mem_req_t mem_req;
  int err_count;
  int n_checks;
  int cyc;

  abs_core u_abs_core (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_rdata(mem_rdata), .mem_req(mem_req)
  );

  abs_mem_model u_abs_mem_model (
    .sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata)
  );

  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  task automatic conclude;
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Ceiling is many times the expected run of about a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high or 20 cycles have passed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check("pready", 32'(pready), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    logic e;
    apb(1'b0, a, 32'h0, x, e);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    rd(a, x);
    check(what, x, exp);
  endtask

  // Start one instruction; the second status read falls after a plain cycle has ended
  // but inside the no-operation cycle of a taken branch
  task automatic run(input logic [15:0] ins, input logic late_busy);
    logic [31:0] x;
    int n;
    wr(ABS_OFF_INSTR, {16'h0000, ins});
    rd(ABS_OFF_CORE, x);
    check("busy early", 32'(x[ABS_CORE_BUSY]), 32'h1);
    rd(ABS_OFF_CORE, x);
    check("busy late", 32'(x[ABS_CORE_BUSY]), 32'(late_busy));
    n = 0;
    while (x[ABS_CORE_BUSY] !== 1'b0 && n < 10) begin
      rd(ABS_OFF_CORE, x);
      n++;
    end
  endtask

  task automatic op(input logic [15:0] ins, input logic [11:0] addr, input logic [7:0] w,
                    input logic [7:0] v, input logic [4:0] st0, input logic [7:0] ew,
                    input logic [7:0] em, input logic [4:0] est);
    wr(ABS_OFF_WREG, {24'h0, w});
    wr(ABS_OFF_STATUS, {27'h0, st0});
    u_abs_mem_model.mem[addr] = v;
    run(ins, 1'b0);
    rdchk("wreg", ABS_OFF_WREG, {24'h0, ew});
    rdchk("status", ABS_OFF_STATUS, {27'h0, est});
    check("memory byte", {24'h0, u_abs_mem_model.mem[addr]}, {24'h0, em});
  endtask

  // Each branch is run once with its flag true and once false; other flags opposite
  task automatic br(input logic [7:0] opc, input int bit_pos, input logic sense,
                    input logic [7:0] n8);
    logic [4:0] st0;
    logic tk;
    logic [31:0] x;
    logic [20:0] epc;
    for (int v = 0; v < 2; v++) begin
      st0 = (v == 1) ? (5'h01 << bit_pos) : (5'h1F & ~(5'h01 << bit_pos));
      tk = (v == 1) == sense;
      epc = 21'h001002 + (tk ? {{12{n8[7]}}, n8, 1'b0} : 21'h0);
      wr(ABS_OFF_PC, 32'h00001000);
      wr(ABS_OFF_STATUS, {27'h0, st0});
      run({opc, n8}, tk);
      rdchk("branch pc", ABS_OFF_PC, {11'h0, epc});
      rdchk("branch status", ABS_OFF_STATUS, {27'h0, st0});
      rd(ABS_OFF_CORE, x);
      check("branch taken", 32'(x[ABS_CORE_TAKEN]), 32'(tk));
    end
  endtask

  task automatic t_reset;
    logic [31:0] x;
    logic e;
    for (int i = 0; i < 8; i++) begin
      rdchk("reset value", 8'(i * 4), 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0, x, e);
    check("unmapped error", 32'(e), 32'h1);
    check("unmapped data", x, 32'h0);
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    wr(ABS_OFF_BANK, 32'h3);
    op(16'h2220, 12'h020, 8'h4D, 8'h02, 5'h1F, 8'h4D, 8'h50, 5'h02);
    op(16'h2145, 12'h345, 8'h7F, 8'h00, 5'h1F, 8'h80, 8'h00, 5'h1A);
    op(16'h2070, 12'hF70, 8'hFF, 8'h00, 5'h01, 8'h00, 8'h00, 5'h07);
    op(16'h2010, 12'h010, 8'h80, 8'h80, 5'h1E, 8'h00, 8'h80, 5'h0D);
    wr(ABS_OFF_CTRL, 32'h1);
    wr(ABS_OFF_INDEX, 32'h100);
    op(16'h2210, 12'h110, 8'h01, 8'h01, 5'h00, 8'h01, 8'h02, 5'h00);
    op(16'h2260, 12'hF60, 8'h01, 8'h03, 5'h00, 8'h01, 8'h04, 5'h00);
    op(16'h235F, 12'h35F, 8'h01, 8'h05, 5'h00, 8'h01, 8'h06, 5'h00);
    wr(ABS_OFF_CTRL, 32'h0);
    op(16'h0B5F, 12'h001, 8'hA3, 8'h5A, 5'h1F, 8'h03, 8'h5A, 5'h0B);
    op(16'h0BF0, 12'h001, 8'hA3, 8'h5A, 5'h04, 8'hA0, 8'h5A, 5'h10);
    op(16'h0B0C, 12'h001, 8'hA3, 8'h5A, 5'h1B, 8'h00, 8'h5A, 5'h0F);
    op(16'h1430, 12'h030, 8'h17, 8'hC2, 5'h1B, 8'h02, 8'hC2, 5'h0B);
    op(16'h1631, 12'h031, 8'h0F, 8'hF0, 5'h0B, 8'h0F, 8'h00, 5'h0F);
    for (int b = 0; b < 8; b++) begin
      op(16'h9040 | 16'(b << 9), 12'h040, 8'h5A, 8'hFF, 5'(b * 3), 8'h5A,
         8'hFF & ~(8'h01 << b), 5'(b * 3));
    end
    op(16'h9F45, 12'h345, 8'h5A, 8'hC7, 5'h15, 8'h5A, 8'h47, 5'h15);
    br(ABS_OPC_BC, ABS_ST_C, 1'b1, 8'h7F);
    br(ABS_OPC_BNC, ABS_ST_C, 1'b0, 8'h80);
    br(ABS_OPC_BN, ABS_ST_N, 1'b1, 8'h05);
    br(ABS_OPC_BNN, ABS_ST_N, 1'b0, 8'hFB);
    br(ABS_OPC_BRANCH_ON_OVERFLOW_CLEAR, ABS_ST_OV, 1'b0, 8'h80);
    br(ABS_OPC_BNZ, ABS_ST_Z, 1'b0, 8'h7F);
    conclude();
  end
endmodule
